// ===== bench/display_and_sensor_bus_commands_tb.sv
`timescale 1ns/10ps
`default_nettype none
module display_and_sensor_bus_commands_tb;
	localparam logic [7:0] FAM = 8'h10; // Arbitrary value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, st, q;
	logic avs_waitrequest, ow_req, ow_ack, report_valid, slot_valid, slot_err, sl_err;
	logic enum_valid = 1'b0;
	logic [4:0] enum_idx = 5'h00;
	logic [63:0] enum_rom = 64'h0;
	logic [63:0] rom;
	logic slow = 1'b0;
	logic [1:0] ow_op, slot_num, sl_num;
	logic [7:0] ow_wdata, ow_rdata, contrast, bl_lcd, bl_key, ec, el, ek;
	logic temp_valid = 1'b0;
	logic [4:0] temp_idx = 5'h00;
	logic [15:0] temp_value = 16'h0;
	logic temp_crc_ok = 1'b1;
	logic [4:0] report_idx, rep_last;
	logic [15:0] slot_value, sl_val;
	logic [39:0] slot_word, sl_word, ew;
	logic [7:0] cd [0:15];
	int seed = 32'h68b6;
	int miscompares = 0;
	int checks_done = 0;
	int rep_n = 0;
	int sl_n = 0;
	int b, i;
	dsb_cmd #(.TICK_CYCLES(50), .FAM_A(FAM)) dsb_cmd_i (.clk(clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .enum_valid(enum_valid), .enum_idx(enum_idx),
		.enum_rom(enum_rom), .ow_req(ow_req), .ow_op(ow_op), .ow_wdata(ow_wdata),
		.ow_ack(ow_ack), .ow_rdata(ow_rdata), .temp_valid(temp_valid), .temp_idx(temp_idx),
		.temp_value(temp_value), .temp_crc_ok(temp_crc_ok), .report_valid(report_valid),
		.report_idx(report_idx), .slot_valid(slot_valid), .slot_num(slot_num),
		.slot_value(slot_value), .slot_word(slot_word), .slot_err(slot_err),
		.contrast(contrast), .bl_lcd(bl_lcd), .bl_key(bl_key));
	dsb_ow_model dsb_ow_model_i (.clk(clk), .rst(rst), .slow(slow), .ow_req(ow_req),
		.ow_op(ow_op), .ow_wdata(ow_wdata), .ow_ack(ow_ack), .ow_rdata(ow_rdata));
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (report_valid === 1'b1) begin
			rep_n++;
			rep_last = report_idx;
		end
		if (slot_valid === 1'b1) begin
			sl_n++;
			sl_num = slot_num;
			sl_err = slot_err;
			sl_word = slot_word;
			sl_val = slot_value;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [9:0] ow_exp(input int k);
		if (k == 0) return {dsb_pkg::OP_RST, 8'h00};
		if (k == 1) return {dsb_pkg::OP_WR, 8'h55};
		if (k < 10) return {dsb_pkg::OP_WR, rom[8*(k-2) +: 8]};
		if (k == 10) return {dsb_pkg::OP_WR, cd[2]};
		return {dsb_pkg::OP_RD, 8'h00};
	endfunction : ow_exp
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic run(input logic [7:0] t, input int len);
		int k;
		bus(1'b1, dsb_pkg::ADR_CTYPE, {24'h0, t}, st);
		bus(1'b1, dsb_pkg::ADR_CLEN, 32'(len), st);
		for (k = 0; k < len; k++) bus(1'b1, 8'h40 + 8'(4*k), {24'h0, cd[k]}, st);
		bus(1'b1, dsb_pkg::ADR_CTRL, 32'h1, st);
		st = 32'h1;
		while (st[0] !== 1'b0) bus(1'b0, dsb_pkg::ADR_CTRL, 32'h0, st);
	endtask : run
	task automatic rsp(input logic [7:0] t, input logic [4:0] l);
		bus(1'b0, dsb_pkg::ADR_RSP, 32'h0, q);
		chk(q, {19'h0, l, t});
	endtask : rsp
	task automatic pulse(input logic e, input logic [4:0] x, input logic c);
		@(posedge clk);
		enum_valid <= e;
		temp_valid <= !e;
		enum_idx <= x;
		temp_idx <= x;
		enum_rom <= rom;
		temp_crc_ok <= c;
		temp_value <= 16'($random(seed));
		@(posedge clk);
		enum_valid <= 1'b0;
		temp_valid <= 1'b0;
	endtask : pulse
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude
	initial begin
		#500000;
		miscompares++;
		conclude();
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		cd[0] = 8'($random(seed) & 32'h7f);
		run(dsb_pkg::CT_CONTRAST, 1);
		ec = cd[0];
		rsp(8'h4d, 5'h0);
		cd[0] = 8'($random(seed));
		cd[1] = 8'($random(seed) & 32'h7f);
		run(dsb_pkg::CT_CONTRAST, 2);
		ec = cd[1];
		chk({24'h0, contrast}, {24'h0, ec});
		cd[0] = 8'hc9;
		run(dsb_pkg::CT_CONTRAST, 1);
		chk({st[1], contrast}, {1'b1, ec});
		rsp(8'h00, 5'h0);
		$display("%0t test contrast done", $time);
		cd[0] = 8'($random(seed));
		run(dsb_pkg::CT_BACKLIGHT, 1);
		chk({bl_lcd, bl_key}, {cd[0], cd[0]});
		cd[1] = 8'($random(seed));
		run(dsb_pkg::CT_BACKLIGHT, 2);
		el = cd[0];
		ek = cd[1];
		chk({bl_lcd, bl_key}, {el, ek});
		run(dsb_pkg::CT_SAVE, 0);
		bus(1'b0, dsb_pkg::ADR_BOOT, 32'h0, q);
		chk(q, {8'h0, ec, el, ek});
		$display("%0t test backlight done", $time);
		rom = {32'($random(seed)), 24'($random(seed)), 8'h2a};
		pulse(1'b1, 5'd5, 1'b1);
		rom = {32'($random(seed)), 24'($random(seed)), dsb_pkg::RSP_FLAG ^ 8'h51};
		pulse(1'b1, 5'd26, 1'b1);
		rom = {32'($random(seed)), 24'($random(seed)), FAM};
		pulse(1'b1, 5'd3, 1'b1);
		bus(1'b0, dsb_pkg::ADR_FOUND, 32'h0, q);
		chk(q, 32'h04000028);
		cd[0] = 8'd3;
		run(dsb_pkg::CT_DEVINFO, 1);
		rsp(8'h52, 5'd9);
		for (i = 0; i < 9; i++) begin
			bus(1'b0, 8'h80 + 8'(4*i), 32'h0, q);
			chk(q, {24'h0, 8'({rom, 8'h03} >> (8*i))});
		end
		$display("%0t test device info done", $time);
		cd[0] = 8'h08;
		cd[1] = 8'h00;
		cd[2] = 8'h00;
		cd[3] = 8'h04;
		run(dsb_pkg::CT_TREPORT, 4);
		rsp(8'h53, 5'h0);
		bus(1'b0, dsb_pkg::ADR_TMASK, 32'h0, q);
		chk(q, {cd[3], cd[2], cd[1], cd[0]});
		@(negedge clk);
		rep_n = 0;
		repeat (100) @(negedge clk);
		chk(32'(rep_n), 32'd4);
		chk({27'h0, rep_last}, 32'd26);
		$display("%0t test reporting done", $time);
		b = dsb_ow_model_i.n;
		slow <= 1'b1;
		cd[0] = 8'd3;
		cd[1] = 8'd2;
		cd[2] = 8'($random(seed));
		run(dsb_pkg::CT_RAW, 3);
		chk(32'(dsb_ow_model_i.n), 32'(b + 13));
		for (i = 0; i < 13; i++) begin
			q = (i == 0 || i > 10) ? 32'h300 : 32'h3ff;
			chk(32'(dsb_ow_model_i.log_q[b+i]) & q, 32'(ow_exp(i)) & q);
		end
		rsp(8'h54, 5'd2);
		for (i = 0; i < 2; i++) begin
			bus(1'b0, 8'h80 + 8'(4*i), 32'h0, q);
			chk(q, {24'h0, 8'h3c + 8'(b + 12 + i)});
		end
		b = dsb_ow_model_i.n;
		slow <= 1'b0;
		cd[0] = 8'd32;
		cd[1] = 8'd0;
		cd[3] = 8'($random(seed));
		run(dsb_pkg::CT_RAW, 4);
		chk(32'(dsb_ow_model_i.n), 32'(b + 2));
		chk({dsb_ow_model_i.log_q[b], dsb_ow_model_i.log_q[b+1]},
			{dsb_pkg::OP_WR, cd[2], dsb_pkg::OP_WR, cd[3]});
		rsp(8'h54, 5'h0);
		$display("%0t test raw done", $time);
		for (i = 1; i < 3; i++) begin
			cd[0] = 8'(i);
			cd[1] = dsb_pkg::SLOT_TEMP;
			cd[2] = (i == 1) ? 8'd3 : 8'd26;
			cd[3] = (i == 1) ? dsb_pkg::DIG_LONG : dsb_pkg::DIG_SHORT;
			cd[4] = (i == 1) ? 8'd11 : 8'd13;
			cd[5] = 8'd1;
			cd[6] = 8'd1;
			run(dsb_pkg::CT_SLOT, 7);
			rsp(8'h55, 5'h0);
			sl_n = 0;
			pulse(1'b0, 5'(cd[2]), 1'b0);
			repeat (4) @(posedge clk);
			chk({30'(sl_n), sl_num}, {30'd1, 2'(i)});
			ew = (i == 1) ? dsb_pkg::ERR_LONG : dsb_pkg::ERR_SHORT;
			chk({sl_err, 7'h0, sl_word[7:0], sl_val}, {1'b1, 7'h0, ew[7:0], temp_value});
			chk(sl_word[39:8], ew[39:8]);
		end
		cd[0] = 8'd1;
		cd[1] = dsb_pkg::SLOT_OFF;
		run(dsb_pkg::CT_SLOT, 2);
		sl_n = 0;
		pulse(1'b0, 5'd3, 1'b1);
		repeat (4) @(posedge clk);
		chk(32'(sl_n), 32'h0);
		cd[1] = 8'd1;
		run(dsb_pkg::CT_SLOT, 7);
		chk(32'(st[1]), 32'h1);
		cd[1] = dsb_pkg::SLOT_TEMP;
		cd[3] = dsb_pkg::DIG_LONG;
		cd[4] = 8'd12;
		run(dsb_pkg::CT_SLOT, 7);
		chk(32'(st[1]), 32'h1);
		$display("%0t test slots done", $time);
		conclude();
	end
endmodule : display_and_sensor_bus_commands_tb
`default_nettype wire

// ===== bench/dsb_ow_model.sv
`timescale 1ns/10ps
`default_nettype none
module dsb_ow_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic ow_req,
	input wire logic [1:0] ow_op,
	input wire logic [7:0] ow_wdata,
	output logic ow_ack,
	output logic [7:0] ow_rdata
);
	logic [9:0] log_q [0:63];
	int n;
	int dly;
	logic busy;
	// One op at a time, never started in the ack cycle; idle read line toggles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			n <= 0;
			dly <= 0;
			busy <= 1'b0;
			ow_ack <= 1'b0;
			ow_rdata <= 8'h00;
		end else begin
			ow_ack <= 1'b0;
			ow_rdata <= ~ow_rdata;
			if (busy && dly == 0) begin
				busy <= 1'b0;
				ow_ack <= 1'b1;
				ow_rdata <= 8'h3c + 8'(n);
			end else if (busy) begin
				dly <= dly - 1;
			end else if (ow_req && !ow_ack) begin
				busy <= 1'b1;
				dly <= slow ? 4 : 0;
				log_q[n[5:0]] <= {ow_op, ow_wdata};
				n <= n + 1;
			end
		end
	end
endmodule : dsb_ow_model
`default_nettype wire

// ===== hdl/dsb_cmd.sv
// Functional notes
// - Two-byte contrast: ignore first, use second
// - Reply type is command type with 0x40
// - One backlight byte sets both backlights
// - Two bytes: display first, keypad second
// - Save-boot captures contrast and backlight settings
// - Store every sensor-bus device found at power-up
// - Device-info reply: index then eight ROM bytes
// - Only supported family codes may report temperature
// - Report mask: four bytes, bit n byte k
// - Each enabled sensor reported once per second
// - Index 32 skips the addressing phase
// - Found index: match command plus stored address
// - Payload of length minus two follows address
// - Read count zero: no read; else reply
// - Four independent live-display slots refresh themselves
// - Bus CRC failure shows short or long error
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module dsb_cmd #(
	parameter int unsigned TICK_CYCLES = 32'(dsb_pkg::TICK_CYC),
	parameter logic [7:0] MATCH_CMD = 8'h55,
	parameter logic [7:0] FAM_A = 8'h10, // Arbitrary value
	parameter logic [7:0] FAM_B = 8'h11 // Arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic enum_valid,
	input wire logic [4:0] enum_idx,
	input wire logic [63:0] enum_rom,
	output logic ow_req,
	output logic [1:0] ow_op,
	output logic [7:0] ow_wdata,
	input wire logic ow_ack,
	input wire logic [7:0] ow_rdata,
	input wire logic temp_valid,
	input wire logic [4:0] temp_idx,
	input wire logic [15:0] temp_value,
	input wire logic temp_crc_ok,
	output logic report_valid,
	output logic [4:0] report_idx,
	output logic slot_valid,
	output logic [1:0] slot_num,
	output logic [15:0] slot_value,
	output logic [39:0] slot_word,
	output logic slot_err,
	output logic [7:0] contrast,
	output logic [7:0] bl_lcd,
	output logic [7:0] bl_key
);
	typedef struct packed {
		dsb_pkg::dsb_st_t st;
		logic busy;
		logic rej;
		logic done;
		logic [7:0] ctype;
		logic [4:0] clen;
		logic [15:0][7:0] cdat;
		logic [7:0] rtype;
		logic [4:0] rlen;
		logic [15:0][7:0] rdat;
		logic [7:0] contrast;
		logic [7:0] bl_lcd;
		logic [7:0] bl_key;
		logic [23:0] boot;
		logic [31:0] tmask;
		logic [31:0] found;
		logic [31:0] tcap;
		logic [31:0] pend;
		logic [63:0] rom;
		logic [3:0] cnt;
		logic [3:0] sl_en;
		logic [3:0][4:0] sl_idx;
		logic [3:0] sl_dig5;
		logic [3:0][3:0] sl_col;
		logic [3:0] sl_row;
		logic [3:0] sl_units;
		logic [3:0] spend;
		logic [3:0][15:0] sval;
		logic [3:0] serr;
		logic ow_req;
		logic [1:0] ow_op;
		logic [7:0] ow_wdata;
		logic rd_ack;
		logic [31:0] rdata;
		logic rep_v;
		logic [4:0] rep_idx;
		logic sl_v;
		logic [1:0] sl_num;
		logic [15:0] sl_val;
		logic [39:0] sl_word;
		logic sl_err;
	} dsb_state_t;

	dsb_state_t s_r;
	dsb_state_t s_nxt;
	logic tick;
	logic [63:0] rom_q;

	function automatic logic [4:0] lsb5(input logic [31:0] v);
		logic [4:0] r;
		r = '0;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction : lsb5

	// Phase after addressing: payload, then read, then done
	function automatic dsb_pkg::dsb_st_t next_phase(input logic [4:0] len, input logic [7:0] rd);
		if (len > dsb_pkg::LEN_RAW_MIN) begin
			return dsb_pkg::ST_OW_WR;
		end else if (rd != 8'h00) begin
			return dsb_pkg::ST_OW_RD;
		end
		return dsb_pkg::ST_FIN;
	endfunction : next_phase

	dsb_tick #(.CYCLES(TICK_CYCLES)) u_tick (
		.clk(clk),
		.rst(rst),
		.tick(tick)
	);

	dsb_rom_mem #(.DEPTH(32), .WIDTH(64), .AW(5)) u_rom (
		.clk(clk),
		.rst(rst),
		.we(enum_valid),
		.waddr(enum_idx),
		.wdata(enum_rom),
		.raddr(s_r.cdat[0][4:0]),
		.rdata(rom_q)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [4:0] ix;
		logic [1:0] sn;
		logic geom_ok;
		ix = '0;
		sn = s_r.cdat[0][1:0];
		geom_ok = (s_r.cdat[3] == dsb_pkg::DIG_SHORT && s_r.cdat[4] <= dsb_pkg::COL_SHORT_MAX)
			|| (s_r.cdat[3] == dsb_pkg::DIG_LONG && s_r.cdat[4] <= dsb_pkg::COL_LONG_MAX);
		s_nxt = s_r;
		s_nxt.rd_ack = 1'b0;
		s_nxt.rep_v = 1'b0;
		s_nxt.sl_v = 1'b0;
		// Power-up enumeration results
		if (enum_valid) begin
			s_nxt.found[enum_idx] = 1'b1;
			s_nxt.tcap[enum_idx] = enum_rom[7:0] == FAM_A || enum_rom[7:0] == FAM_B;
		end
		// Bus slave: writes stall while a command runs
		if (avs_write && !s_r.busy) begin
			if (avs_address == dsb_pkg::ADR_CTYPE) begin
				s_nxt.ctype = avs_writedata[7:0];
			end else if (avs_address == dsb_pkg::ADR_CLEN) begin
				s_nxt.clen = avs_writedata[4:0];
			end else if (avs_address == dsb_pkg::ADR_CTRL && avs_writedata[0]) begin
				s_nxt.st = dsb_pkg::ST_DEC;
				s_nxt.busy = 1'b1;
				s_nxt.done = 1'b0;
				s_nxt.rej = 1'b0;
			end else if (avs_address[7:6] == dsb_pkg::PAGE_CDAT) begin
				s_nxt.cdat[avs_address[5:2]] = avs_writedata[7:0];
			end
		end
		if (avs_read && !s_r.rd_ack) begin
			s_nxt.rd_ack = 1'b1;
			s_nxt.rdata = '0;
			case (avs_address)
				dsb_pkg::ADR_CTYPE: s_nxt.rdata[7:0] = s_r.ctype;
				dsb_pkg::ADR_CLEN: s_nxt.rdata[4:0] = s_r.clen;
				dsb_pkg::ADR_CTRL: s_nxt.rdata[2:0] = {s_r.done, s_r.rej, s_r.busy};
				dsb_pkg::ADR_RSP: s_nxt.rdata[12:0] = {s_r.rlen, s_r.rtype};
				dsb_pkg::ADR_CONTRAST: s_nxt.rdata[7:0] = s_r.contrast;
				dsb_pkg::ADR_BACKLIGHT: s_nxt.rdata[15:0] = {s_r.bl_key, s_r.bl_lcd};
				dsb_pkg::ADR_TMASK: s_nxt.rdata = s_r.tmask;
				dsb_pkg::ADR_BOOT: s_nxt.rdata[23:0] = s_r.boot;
				dsb_pkg::ADR_FOUND: s_nxt.rdata = s_r.found;
				default: begin
					if (avs_address[7:6] == dsb_pkg::PAGE_CDAT) begin
						s_nxt.rdata[7:0] = s_r.cdat[avs_address[5:2]];
					end else if (avs_address[7:6] == dsb_pkg::PAGE_RDAT) begin
						s_nxt.rdata[7:0] = s_r.rdat[avs_address[5:2]];
					end else if (avs_address[7:6] == dsb_pkg::PAGE_SLOT
						&& avs_address[5:4] == dsb_pkg::SLOT_SUB) begin
						sn = avs_address[3:2];
						s_nxt.rdata[12:0] = {s_r.sl_units[sn], s_r.sl_row[sn], s_r.sl_col[sn],
							s_r.sl_dig5[sn], s_r.sl_idx[sn], s_r.sl_en[sn]};
						sn = s_r.cdat[0][1:0];
					end
				end
			endcase
		end
		////////////////////////////////////////////////////////////////////////
		case (s_r.st)
			dsb_pkg::ST_IDLE: begin
			end
			dsb_pkg::ST_DEC: begin
				s_nxt.rtype = s_r.ctype | dsb_pkg::RSP_FLAG;
				s_nxt.rlen = '0;
				s_nxt.cnt = '0;
				s_nxt.st = dsb_pkg::ST_REJ;
				case (s_r.ctype)
					dsb_pkg::CT_CONTRAST: begin
						if (s_r.clen == 5'h01 && s_r.cdat[0] <= dsb_pkg::CONTRAST_MAX) begin
							s_nxt.contrast = s_r.cdat[0];
							s_nxt.st = dsb_pkg::ST_FIN;
						end else if (s_r.clen == 5'h02) begin
							s_nxt.contrast = s_r.cdat[1];
							s_nxt.st = dsb_pkg::ST_FIN;
						end
					end
					dsb_pkg::CT_BACKLIGHT: begin
						if (s_r.clen == 5'h01) begin
							s_nxt.bl_lcd = s_r.cdat[0];
							s_nxt.bl_key = s_r.cdat[0];
							s_nxt.st = dsb_pkg::ST_FIN;
						end else if (s_r.clen == 5'h02) begin
							s_nxt.bl_lcd = s_r.cdat[0];
							s_nxt.bl_key = s_r.cdat[1];
							s_nxt.st = dsb_pkg::ST_FIN;
						end
					end
					dsb_pkg::CT_SAVE: begin
						if (s_r.clen == 5'h00) begin
							s_nxt.boot = {s_r.contrast, s_r.bl_lcd, s_r.bl_key};
							s_nxt.st = dsb_pkg::ST_FIN;
						end
					end
					dsb_pkg::CT_DEVINFO: begin
						if (s_r.clen == 5'h01 && s_r.cdat[0] < dsb_pkg::IDX_LIMIT) begin
							s_nxt.st = dsb_pkg::ST_ROM;
						end
					end
					dsb_pkg::CT_TREPORT: begin
						if (s_r.clen == dsb_pkg::LEN_TREPORT) begin
							s_nxt.tmask = {s_r.cdat[3], s_r.cdat[2], s_r.cdat[1], s_r.cdat[0]};
							s_nxt.st = dsb_pkg::ST_FIN;
						end
					end
					dsb_pkg::CT_RAW: begin
						if (s_r.clen >= dsb_pkg::LEN_RAW_MIN && s_r.clen <= dsb_pkg::LEN_RAW_MAX
							&& s_r.cdat[0] <= dsb_pkg::IDX_LIMIT
							&& s_r.cdat[1] <= dsb_pkg::RD_MAX) begin
							if (s_r.cdat[0] < dsb_pkg::IDX_LIMIT && s_r.found[s_r.cdat[0][4:0]]) begin
								s_nxt.st = dsb_pkg::ST_ROM;
							end else begin
								s_nxt.st = next_phase(s_r.clen, s_r.cdat[1]);
							end
						end
					end
					dsb_pkg::CT_SLOT: begin
						if (s_r.cdat[0] <= dsb_pkg::SLOT_LAST) begin
							if (s_r.cdat[1] == dsb_pkg::SLOT_OFF && s_r.clen == dsb_pkg::LEN_SLOT_OFF) begin
								s_nxt.sl_en[sn] = 1'b0;
								s_nxt.st = dsb_pkg::ST_FIN;
							end else if (s_r.cdat[1] == dsb_pkg::SLOT_TEMP
								&& s_r.clen == dsb_pkg::LEN_SLOT_TEMP
								&& s_r.cdat[2] < dsb_pkg::IDX_LIMIT && s_r.tcap[s_r.cdat[2][4:0]]
								&& geom_ok && s_r.cdat[5] <= dsb_pkg::ROW_MAX
								&& s_r.cdat[6] <= dsb_pkg::UNITS_MAX) begin
								s_nxt.sl_en[sn] = 1'b1;
								s_nxt.sl_idx[sn] = s_r.cdat[2][4:0];
								s_nxt.sl_dig5[sn] = s_r.cdat[3] == dsb_pkg::DIG_LONG;
								s_nxt.sl_col[sn] = s_r.cdat[4][3:0];
								s_nxt.sl_row[sn] = s_r.cdat[5][0];
								s_nxt.sl_units[sn] = s_r.cdat[6][0];
								s_nxt.st = dsb_pkg::ST_FIN;
							end
						end
					end
					default: begin
					end
				endcase
			end
			dsb_pkg::ST_ROM: begin
				if (s_r.ctype == dsb_pkg::CT_DEVINFO) begin
					s_nxt.rdat[0] = s_r.cdat[0];
					for (int i = 0; i < 8; i++) begin
						s_nxt.rdat[i + 1] = rom_q[8 * i +: 8];
					end
					s_nxt.rlen = dsb_pkg::LEN_DEVINFO_RSP;
					s_nxt.st = dsb_pkg::ST_FIN;
				end else begin
					s_nxt.rom = rom_q;
					s_nxt.st = dsb_pkg::ST_OW_RST;
				end
			end
			dsb_pkg::ST_OW_RST: begin
				if (ow_ack) begin
					s_nxt.st = dsb_pkg::ST_OW_MATCH;
				end
			end
			dsb_pkg::ST_OW_MATCH: begin
				if (ow_ack) begin
					s_nxt.st = dsb_pkg::ST_OW_ADDR;
				end
			end
			dsb_pkg::ST_OW_ADDR: begin
				if (ow_ack) begin
					s_nxt.cnt = s_r.cnt + 4'h1;
					if (s_r.cnt == 4'h7) begin
						s_nxt.cnt = '0;
						s_nxt.st = next_phase(s_r.clen, s_r.cdat[1]);
					end
				end
			end
			dsb_pkg::ST_OW_WR: begin
				if (ow_ack) begin
					s_nxt.cnt = s_r.cnt + 4'h1;
					if (s_r.cnt == 4'(s_r.clen - 5'h03)) begin
						s_nxt.cnt = '0;
						s_nxt.st = s_r.cdat[1] != 8'h00 ? dsb_pkg::ST_OW_RD : dsb_pkg::ST_FIN;
					end
				end
			end
			dsb_pkg::ST_OW_RD: begin
				if (ow_ack) begin
					s_nxt.rdat[s_r.cnt] = ow_rdata;
					s_nxt.cnt = s_r.cnt + 4'h1;
					if (s_r.cnt == 4'(s_r.cdat[1] - 8'h01)) begin
						s_nxt.rlen = s_r.cdat[1][4:0];
						s_nxt.st = dsb_pkg::ST_FIN;
					end
				end
			end
			dsb_pkg::ST_FIN: begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
				s_nxt.st = dsb_pkg::ST_IDLE;
			end
			dsb_pkg::ST_REJ: begin
				s_nxt.busy = 1'b0;
				s_nxt.rej = 1'b1;
				s_nxt.rtype = '0;
				s_nxt.st = dsb_pkg::ST_IDLE;
			end
			default: begin
				s_nxt.st = dsb_pkg::ST_IDLE;
				s_nxt.busy = 1'b0;
			end
		endcase
		// Bus request follows the next state so it is registered
		s_nxt.ow_req = 1'b1;
		s_nxt.ow_op = dsb_pkg::OP_WR;
		s_nxt.ow_wdata = '0;
		case (s_nxt.st)
			dsb_pkg::ST_OW_RST: s_nxt.ow_op = dsb_pkg::OP_RST;
			dsb_pkg::ST_OW_MATCH: s_nxt.ow_wdata = MATCH_CMD;
			dsb_pkg::ST_OW_ADDR: s_nxt.ow_wdata = s_nxt.rom[{s_nxt.cnt[2:0], 3'h0} +: 8];
			dsb_pkg::ST_OW_WR: s_nxt.ow_wdata = s_nxt.cdat[s_nxt.cnt + 4'h2];
			dsb_pkg::ST_OW_RD: s_nxt.ow_op = dsb_pkg::OP_RD;
			default: s_nxt.ow_req = 1'b0;
		endcase
		////////////////////////////////////////////////////////////////////////
		// Once-a-second reports, one pulse per enabled sensor
		if (tick) begin
			s_nxt.pend = s_r.tmask & s_r.tcap;
		end else if (s_r.pend != 32'h0) begin
			ix = lsb5(s_r.pend);
			s_nxt.rep_v = 1'b1;
			s_nxt.rep_idx = ix;
			s_nxt.pend[ix] = 1'b0;
		end
		// Slot refresh: emit first, so a fresh reading wins
		if (s_r.spend != 4'h0) begin
			ix = lsb5({28'h0, s_r.spend});
			s_nxt.sl_v = 1'b1;
			s_nxt.sl_num = ix[1:0];
			s_nxt.sl_val = s_r.sval[ix[1:0]];
			s_nxt.sl_err = s_r.serr[ix[1:0]];
			s_nxt.sl_word = !s_r.serr[ix[1:0]] ? 40'h0
				: s_r.sl_dig5[ix[1:0]] ? dsb_pkg::ERR_LONG : dsb_pkg::ERR_SHORT;
			s_nxt.spend[ix[1:0]] = 1'b0;
		end
		if (temp_valid) begin
			for (int i = 0; i < 4; i++) begin
				if (s_nxt.sl_en[i] && s_nxt.sl_idx[i] == temp_idx) begin
					s_nxt.spend[i] = 1'b1;
					s_nxt.sval[i] = temp_value;
					s_nxt.serr[i] = !temp_crc_ok;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign avs_waitrequest = (avs_read && !s_r.rd_ack) || (avs_write && s_r.busy);
	assign avs_readdata = s_r.rdata;
	assign ow_req = s_r.ow_req;
	assign ow_op = s_r.ow_op;
	assign ow_wdata = s_r.ow_wdata;
	assign report_valid = s_r.rep_v;
	assign report_idx = s_r.rep_idx;
	assign slot_valid = s_r.sl_v;
	assign slot_num = s_r.sl_num;
	assign slot_value = s_r.sl_val;
	assign slot_word = s_r.sl_word;
	assign slot_err = s_r.sl_err;
	assign contrast = s_r.contrast;
	assign bl_lcd = s_r.bl_lcd;
	assign bl_key = s_r.bl_key;

	////////////////////////////////////////////////////////////////////////////
	reply_type_a: assert property (@(posedge clk) disable iff (rst)
		s_r.st == dsb_pkg::ST_FIN |-> s_r.rtype == (s_r.ctype | dsb_pkg::RSP_FLAG) ##1 s_r.done)
		else $error("reply type not command type with 0x40");
	contrast_fine_a: assert property (@(posedge clk) disable iff (rst)
		s_r.st == dsb_pkg::ST_DEC && s_r.ctype == dsb_pkg::CT_CONTRAST && s_r.clen == 5'h02
		|=> s_r.contrast == $past(s_r.cdat[1]) && s_r.st == dsb_pkg::ST_FIN)
		else $error("two-byte contrast not taken from second byte");
	backlight_both_a: assert property (@(posedge clk) disable iff (rst)
		s_r.st == dsb_pkg::ST_DEC && s_r.ctype == dsb_pkg::CT_BACKLIGHT && s_r.clen == 5'h01
		|=> s_r.bl_lcd == $past(s_r.cdat[0]) && s_r.bl_key == $past(s_r.cdat[0]))
		else $error("one-byte backlight not applied to both");
	devinfo_reply_a: assert property (@(posedge clk) disable iff (rst)
		s_r.st == dsb_pkg::ST_ROM && s_r.ctype == dsb_pkg::CT_DEVINFO
		|=> s_r.rlen == dsb_pkg::LEN_DEVINFO_RSP && s_r.rdat[1] == $past(rom_q[7:0]))
		else $error("device info reply malformed");
	raw_noaddr_a: assert property (@(posedge clk) disable iff (rst)
		s_r.st == dsb_pkg::ST_DEC && s_r.ctype == dsb_pkg::CT_RAW && s_r.cdat[0] == 8'h20
		|=> s_r.st != dsb_pkg::ST_ROM && s_r.st != dsb_pkg::ST_OW_RST)
		else $error("address phase run for index 32");
	report_cap_a: assert property (@(posedge clk) disable iff (rst)
		report_valid |-> s_r.tcap[report_idx] && s_r.tmask[report_idx])
		else $error("report for unsupported or disabled sensor");
	reject_keep_a: assert property (@(posedge clk) disable iff (rst)
		s_r.st == dsb_pkg::ST_DEC ##1 s_r.st == dsb_pkg::ST_REJ
		|-> $stable(s_r.tmask) && $stable(s_r.contrast) && $stable(s_r.sl_en))
		else $error("rejected request changed a setting");
	slot_err_a: assert property (@(posedge clk) disable iff (rst)
		slot_valid && slot_err |-> slot_word == (s_r.sl_dig5[slot_num] ? dsb_pkg::ERR_LONG
			: dsb_pkg::ERR_SHORT))
		else $error("error word wrong for slot width");
	read_done_a: assert property (@(posedge clk) disable iff (rst)
		s_r.st == dsb_pkg::ST_OW_RD ##1 s_r.st == dsb_pkg::ST_FIN
		|-> s_r.rlen == s_r.cdat[1][4:0] ##2 !s_r.busy)
		else $error("read reply length wrong");
endmodule : dsb_cmd
`default_nettype wire

// ===== hdl/dsb_pkg.sv
package dsb_pkg;
	localparam logic [7:0] RSP_FLAG = 8'h40;
	localparam logic [7:0] CT_SAVE = 8'h04;
	localparam logic [7:0] CT_CONTRAST = 8'h0d;
	localparam logic [7:0] CT_BACKLIGHT = 8'h0e;
	localparam logic [7:0] CT_DEVINFO = 8'h12;
	localparam logic [7:0] CT_TREPORT = 8'h13;
	localparam logic [7:0] CT_RAW = 8'h14;
	localparam logic [7:0] CT_SLOT = 8'h15;
	localparam logic [7:0] CONTRAST_MAX = 8'hc8;
	localparam logic [7:0] IDX_LIMIT = 8'h20;
	localparam logic [7:0] RD_MAX = 8'h0e;
	localparam logic [4:0] LEN_RAW_MIN = 5'h02;
	localparam logic [4:0] LEN_RAW_MAX = 5'h10;
	localparam logic [4:0] LEN_DEVINFO_RSP = 5'h09;
	localparam logic [4:0] LEN_TREPORT = 5'h04;
	localparam logic [4:0] LEN_SLOT_OFF = 5'h02;
	localparam logic [4:0] LEN_SLOT_TEMP = 5'h07;
	localparam logic [7:0] SLOT_LAST = 8'h03;
	localparam logic [7:0] SLOT_OFF = 8'h00;
	localparam logic [7:0] SLOT_TEMP = 8'h02;
	localparam logic [7:0] DIG_SHORT = 8'h03;
	localparam logic [7:0] DIG_LONG = 8'h05;
	localparam logic [7:0] COL_SHORT_MAX = 8'h0d;
	localparam logic [7:0] COL_LONG_MAX = 8'h0b;
	localparam logic [7:0] ROW_MAX = 8'h01;
	localparam logic [7:0] UNITS_MAX = 8'h01;
	localparam logic [39:0] ERR_SHORT = 40'h4552522020;
	localparam logic [39:0] ERR_LONG = 40'h4552524f52;
	////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] ADR_CTYPE = 8'h00;
	localparam logic [7:0] ADR_CLEN = 8'h04;
	localparam logic [7:0] ADR_CTRL = 8'h08;
	localparam logic [7:0] ADR_RSP = 8'h0c;
	localparam logic [7:0] ADR_CONTRAST = 8'h10;
	localparam logic [7:0] ADR_BACKLIGHT = 8'h14;
	localparam logic [7:0] ADR_TMASK = 8'h18;
	localparam logic [7:0] ADR_BOOT = 8'h1c;
	localparam logic [7:0] ADR_FOUND = 8'h20;
	localparam logic [1:0] PAGE_SLOT = 2'h0;
	localparam logic [1:0] SLOT_SUB = 2'h3;
	localparam logic [1:0] PAGE_CDAT = 2'h1;
	localparam logic [1:0] PAGE_RDAT = 2'h2;
	////////////////////////////////////////////////////////////////////////////
	localparam longint unsigned TICK_NS = 64'd1000000000;
	localparam longint unsigned CLK_NS = 64'd10;
	localparam longint unsigned TICK_CYC = TICK_NS / CLK_NS;
	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_DEC = 4'h1,
		ST_ROM = 4'h2,
		ST_OW_RST = 4'h3,
		ST_OW_MATCH = 4'h4,
		ST_OW_ADDR = 4'h5,
		ST_OW_WR = 4'h6,
		ST_OW_RD = 4'h7,
		ST_FIN = 4'h8,
		ST_REJ = 4'h9
	} dsb_st_t;
	typedef enum logic [1:0] {
		OP_RST = 2'h0,
		OP_WR = 2'h1,
		OP_RD = 2'h2
	} dsb_op_t;
endpackage : dsb_pkg

// ===== hdl/dsb_rom_mem.sv
`timescale 1ns/10ps
`default_nettype none
module dsb_rom_mem #(
	parameter int unsigned DEPTH = 32,
	parameter int unsigned WIDTH = 64,
	parameter int unsigned AW = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read data always comes out of a register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule : dsb_rom_mem
`default_nettype wire

// ===== hdl/dsb_tick.sv
`timescale 1ns/10ps
`default_nettype none
module dsb_tick #(
	parameter int unsigned CYCLES = 100
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} dsb_tick_t;
	dsb_tick_t s_r;
	dsb_tick_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (s_r.cnt == 32'(CYCLES - 1)) begin
			s_nxt.cnt = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 32'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign tick = s_r.tick;
endmodule : dsb_tick
`default_nettype wire
